// [hdl/param_bank_pkg.sv]
package param_bank_pkg;

  // ----------------------------------------------------------------
  // bus and storage shape
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 16;
  localparam int          NUM_ENTRIES = 22;

  // ----------------------------------------------------------------
  // plain parameter entries: offset, lowest, highest, reset value
  // ----------------------------------------------------------------
  localparam logic [15:0] ENTRY_ADDR [NUM_ENTRIES] = '{
    16'h123b, 16'h323c, 16'h123d, 16'h223d, 16'h323d, 16'h123e, 16'h223e, 16'h323e,
    16'h123f, 16'h1240, 16'h2240, 16'h1241, 16'h2241, 16'h1245, 16'h1246, 16'h1247,
    16'h1248, 16'h1249, 16'h124a, 16'h124b, 16'h124c, 16'h124d};
  localparam logic [15:0] ENTRY_MIN [NUM_ENTRIES] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0014, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0005};
  localparam logic [15:0] ENTRY_MAX [NUM_ENTRIES] = '{
    16'h0001, 16'h00c8, 16'h01f4, 16'h01f4, 16'h01f4, 16'h0005, 16'h0004, 16'h0001,
    16'h00c8, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h0002, 16'h9c40, 16'h0032,
    16'h0050, 16'h0258, 16'h0001, 16'h0050, 16'h0258, 16'h0096};
  localparam logic [15:0] ENTRY_RESET [NUM_ENTRIES] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0005};

  // entry indices the block's own logic reads
  localparam int          IDX_BOOST_METHOD_M1 = 0;
  localparam int          IDX_CONTROL_M1      = 5;
  localparam int          IDX_DCB_ENABLE      = 13;
  localparam int          IDX_DCB_TRIGGER     = 14;
  localparam int          IDX_DCB_WAIT        = 15;
  localparam int          IDX_DCB_FORCE_DEC   = 16;
  localparam int          IDX_DCB_TIME_DEC    = 17;
  localparam int          IDX_DCB_DETECT      = 18;
  localparam int          IDX_DCB_FORCE_START = 19;
  localparam int          IDX_DCB_TIME_START  = 20;
  localparam int          IDX_DCB_CARRIER     = 21;

  // carrier ceiling on the larger frames
  localparam logic [15:0] CARRIER_MAX_LARGE   = 16'h0064;

  // ----------------------------------------------------------------
  // split upper frequency limit
  // ----------------------------------------------------------------
  localparam logic [15:0] FREQ_LIMIT_HIGH_ADDR = 16'h124f;
  localparam logic [15:0] FREQ_LIMIT_LOW_ADDR  = 16'h1250;
  localparam logic [31:0] FREQ_LIMIT_MIN       = 32'h0000_0032;
  localparam logic [31:0] FREQ_LIMIT_MAX       = 32'h0000_9c40;
  localparam logic [31:0] FREQ_LIMIT_RESET     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [15:0] DCB_DISABLED     = 16'h0000;
  localparam logic [15:0] DCB_ENABLED      = 16'h0001;
  localparam logic [15:0] DCB_AT_FREQ_ONLY = 16'h0002;
  localparam logic [15:0] DETECT_EDGE      = 16'h0000;
  localparam logic [15:0] BOOST_AUTO       = 16'h0001;

  // ----------------------------------------------------------------
  // timing: braking wait and duration count in 0.1 s steps
  // ----------------------------------------------------------------
  localparam int          CLK_FREQ_MHZ     = 100;
  localparam int          BRAKE_STEP_US    = 100000;
  localparam int          BRAKE_STEP_CYCLES = BRAKE_STEP_US * CLK_FREQ_MHZ;
  localparam int          STEP_CNT_W       = 24;

  typedef enum logic [2:0] {
    BRK_IDLE  = 3'b001,
    BRK_WAIT  = 3'b010,
    BRK_APPLY = 3'b100
  } brake_state_t;

endpackage : param_bank_pkg

// [hdl/drive_boost_brake_param_bank.sv]
`timescale 1ns/10ps
module drive_boost_brake_param_bank
  import param_bank_pkg::*;
#(
  parameter int STEP_CYCLES = BRAKE_STEP_CYCLES  // cycles per 0.1 s
)(
  input  wire logic                            core_clk,                 // clock
  input  wire logic                            rst,                      // sync reset
  input  wire logic [param_bank_pkg::ADDR_W-1:0] addr,                   // register address
  input  wire logic [param_bank_pkg::DATA_W-1:0] wdata,                  // write data
  input  wire logic                            wr,                       // write strobe
  input  wire logic                            rd,                       // read strobe
  output logic      [param_bank_pkg::DATA_W-1:0] rdata,                  // read data
  output logic                                 wr_rejected,              // write refused
  input  wire logic                            external_brake_input,     // brake pin
  input  wire logic                            large_model,              // frame strap pin
  input  wire logic                            decelerating,             // drive slowing
  input  wire logic                            start_request,            // start pulse
  input  wire logic [15:0]                     output_freq,              // 0.01 hz
  input  wire logic [31:0]                     maximum_output_frequency, // 0.01 hz
  output logic                                 dcb_active,               // braking on
  output logic      [15:0]                     dcb_force,                // percent
  output logic      [15:0]                     dcb_carrier,              // 0.1 khz
  output logic                                 start_brake_done,         // start brake over
  output logic      [5:0]                      control_mode_m1,          // one-hot method
  output logic                                 auto_boost_m1,            // auto boost on
  output logic      [31:0]                     freq_upper_limit          // 0.01 hz
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic        brake_meta;
  logic        brake_sync;
  logic        brake_prev;
  logic        model_meta;
  logic        model_sync;

  always_ff @(posedge core_clk)
  begin
    brake_meta <= external_brake_input;
    brake_sync <= brake_meta;
    brake_prev <= brake_sync;
    model_meta <= large_model;
    model_sync <= model_meta;
  end

  // ----------------------------------------------------------------
  // plain parameter entries
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]      bank [NUM_ENTRIES];
  logic [NUM_ENTRIES-1:0] hit;
  logic [NUM_ENTRIES-1:0] in_range;
  logic [DATA_W-1:0]      entry_max [NUM_ENTRIES];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ENTRIES; gi++)
    begin : g_entry
      assign hit[gi] = (addr == ENTRY_ADDR[gi]);
      // carrier ceiling follows the frame size
      if (gi == IDX_DCB_CARRIER)
      begin : g_carrier
        assign entry_max[gi] = model_sync ? CARRIER_MAX_LARGE : ENTRY_MAX[gi];
      end
      else
      begin : g_fixed
        assign entry_max[gi] = ENTRY_MAX[gi];
      end
      assign in_range[gi] = (wdata >= ENTRY_MIN[gi]) && (wdata <= entry_max[gi]);

      always_ff @(posedge core_clk)
      begin
        if (rst)
          bank[gi] <= ENTRY_RESET[gi];
        else if (wr && hit[gi] && in_range[gi])
          bank[gi] <= wdata;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // split upper limit: high word is staged, low word commits the pair
  // ----------------------------------------------------------------
  logic [15:0] limit_high_staged;
  logic [31:0] limit_candidate;
  logic        limit_ok;
  logic        hit_limit_high;
  logic        hit_limit_low;

  assign hit_limit_high  = (addr == FREQ_LIMIT_HIGH_ADDR);
  assign hit_limit_low   = (addr == FREQ_LIMIT_LOW_ADDR);
  assign limit_candidate = {limit_high_staged, wdata};
  assign limit_ok = (limit_candidate == 32'h0000_0000) ||
                    ((limit_candidate >= FREQ_LIMIT_MIN) &&
                     (limit_candidate <= FREQ_LIMIT_MAX) &&
                     (limit_candidate < maximum_output_frequency));

  // the pair only takes effect on the low word, so a lone high write is inert
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      limit_high_staged <= FREQ_LIMIT_RESET[31:16];
      freq_upper_limit  <= FREQ_LIMIT_RESET;
    end
    else
    begin
      if (wr && hit_limit_high)
        limit_high_staged <= wdata;
      if (wr && hit_limit_low && limit_ok)
        freq_upper_limit <= limit_candidate;
    end
  end

  // ----------------------------------------------------------------
  // register read and write answer
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] read_mux;
  logic              mapped_ok;
  logic              write_bad;

  always_comb
  begin
    read_mux  = 16'h0000;
    mapped_ok = 1'b0;
    for (int i = 0; i < NUM_ENTRIES; i++)
    begin
      if (hit[i])
      begin
        read_mux  = bank[i];
        mapped_ok = in_range[i];
      end
    end
    if (hit_limit_high)
    begin
      read_mux  = freq_upper_limit[31:16];
      mapped_ok = 1'b1;
    end
    if (hit_limit_low)
    begin
      read_mux  = freq_upper_limit[15:0];
      mapped_ok = limit_ok;
    end
  end

  // reserved and unmapped addresses read zero and refuse writes
  assign write_bad = wr && !mapped_ok;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rdata       <= 16'h0000;
      wr_rejected <= 1'b0;
    end
    else
    begin
      rdata       <= rd ? read_mux : 16'h0000;
      wr_rejected <= write_bad;
    end
  end

  // ----------------------------------------------------------------
  // decoded modes
  // ----------------------------------------------------------------
  logic [5:0] next_control_mode_m1;
  logic [2:0] method_m1;

  assign method_m1 = bank[IDX_CONTROL_M1][2:0];
  // stored code never exceeds 5, so the shift stays inside six bits
  assign next_control_mode_m1 = 6'h01 << method_m1;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      control_mode_m1 <= 6'h01;
      auto_boost_m1   <= 1'b0;
      dcb_carrier     <= ENTRY_RESET[IDX_DCB_CARRIER];
    end
    else
    begin
      control_mode_m1 <= next_control_mode_m1;
      auto_boost_m1   <= (bank[IDX_BOOST_METHOD_M1] == BOOST_AUTO);
      dcb_carrier     <= bank[IDX_DCB_CARRIER];
    end
  end

  // ----------------------------------------------------------------
  // dc braking sequencer
  // ----------------------------------------------------------------
  brake_state_t            state;
  brake_state_t            next_state;
  logic [STEP_CNT_W-1:0]   tick_cnt;
  logic                    tick;
  logic [15:0]             step_cnt;
  logic                    from_start;
  logic                    level_hold;
  logic                    freq_reached;
  logic                    brake_edge;
  logic                    level_mode;
  logic                    input_trig;
  logic                    decel_trig;
  logic                    start_trig;
  logic [15:0]             apply_time;
  logic                    apply_over;

  assign tick         = (tick_cnt == STEP_CNT_W'(STEP_CYCLES - 1));
  assign freq_reached = decelerating && (output_freq <= bank[IDX_DCB_TRIGGER]);
  assign brake_edge   = brake_sync && !brake_prev;
  assign level_mode   = (bank[IDX_DCB_DETECT] != DETECT_EDGE);
  // brake input only counts when braking is plainly enabled
  assign input_trig   = (bank[IDX_DCB_ENABLE] == DCB_ENABLED) &&
                        (level_mode ? brake_sync : brake_edge);
  assign decel_trig   = (bank[IDX_DCB_ENABLE] != DCB_DISABLED) && freq_reached;
  assign start_trig   = (bank[IDX_DCB_ENABLE] == DCB_ENABLED) && start_request;
  assign apply_time   = from_start ? bank[IDX_DCB_TIME_START] : bank[IDX_DCB_TIME_DEC];
  // level hold keeps braking while the input stays high
  assign apply_over   = level_hold ? !brake_sync : (step_cnt >= apply_time);

  always_comb
  begin
    next_state = state;
    case (state)
      BRK_IDLE:
      begin
        if (start_trig)
          next_state = BRK_APPLY;
        else if (input_trig || decel_trig)
          next_state = (bank[IDX_DCB_WAIT] == 16'h0000) ? BRK_APPLY : BRK_WAIT;
      end
      BRK_WAIT:
      begin
        if (tick && (step_cnt + 16'h0001 >= bank[IDX_DCB_WAIT]))
          next_state = BRK_APPLY;
      end
      BRK_APPLY:
      begin
        if (apply_over)
          next_state = BRK_IDLE;
      end
      default:
      begin
        next_state = BRK_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state <= BRK_IDLE;
    else
      state <= next_state;
  end

  // step prescaler and step counter restart at each state change
  always_ff @(posedge core_clk)
  begin
    if (rst || (next_state != state))
    begin
      tick_cnt <= '0;
      step_cnt <= 16'h0000;
    end
    else if (state != BRK_IDLE)
    begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (tick)
        step_cnt <= step_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      from_start <= 1'b0;
      level_hold <= 1'b0;
    end
    else if (state == BRK_IDLE)
    begin
      from_start <= start_trig;
      level_hold <= !start_trig && input_trig && level_mode;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dcb_active       <= 1'b0;
      dcb_force        <= 16'h0000;
      start_brake_done <= 1'b0;
    end
    else
    begin
      dcb_active       <= (next_state == BRK_APPLY);
      dcb_force        <= (next_state != BRK_APPLY) ? 16'h0000 :
                          (next_state == state) ? dcb_force :
                          (from_start || (state == BRK_IDLE && start_trig)) ?
                          bank[IDX_DCB_FORCE_START] : bank[IDX_DCB_FORCE_DEC];
      start_brake_done <= (state == BRK_APPLY) && (next_state == BRK_IDLE) && from_start;
    end
  end

endmodule : drive_boost_brake_param_bank

// [tb/net_master.sv]
`timescale 1ns/10ps
module net_master
  import param_bank_pkg::*;
(
  input  wire logic                              core_clk,    // clock
  input  wire logic [param_bank_pkg::DATA_W-1:0] rdata,       // read data
  input  wire logic                              wr_rejected, // refusal pulse
  output logic      [param_bank_pkg::ADDR_W-1:0] addr,        // address
  output logic      [param_bank_pkg::DATA_W-1:0] wdata,       // write data
  output logic                                   wr,          // write strobe
  output logic                                   rd           // read strobe
);
  initial
  begin
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // data goes to the inverse once the strobe drops, so stale data never looks valid
  task automatic write(input logic [15:0] a, input logic [15:0] d, output logic rej);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    wdata <= ~d;
    #1 rej = wr_rejected;
  endtask : write

  task automatic read(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : read

  // high word first, the low word commits the pair
  task automatic write_limit(input logic [15:0] hi, input logic [15:0] lo, output logic rej);
    write(FREQ_LIMIT_HIGH_ADDR, hi, rej);
    write(FREQ_LIMIT_LOW_ADDR, lo, rej);
  endtask : write_limit
endmodule : net_master

// [tb/param_bank_chk.sv]
`timescale 1ns/10ps
module param_bank_chk
  import param_bank_pkg::*;
(
  input wire logic                              core_clk,         // clock
  input wire logic                              rst,              // sync reset
  input wire logic [param_bank_pkg::ADDR_W-1:0] addr,             // address
  input wire logic [param_bank_pkg::DATA_W-1:0] wdata,            // write data
  input wire logic                              wr,               // write strobe
  input wire logic                              rd,               // read strobe
  input wire logic [param_bank_pkg::DATA_W-1:0] rdata,            // read data
  input wire logic                              wr_rejected,      // refusal
  input wire logic                              dcb_active,       // braking on
  input wire logic [15:0]                       dcb_force,        // percent
  input wire logic [5:0]                        control_mode_m1,  // one-hot
  input wire logic [31:0]                       freq_upper_limit  // limit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_read_quiet: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  chk_reject_cause: assert property (wr_rejected |-> $past(wr))
    else $error("refusal without write");
  chk_force_range: assert property (wr && addr == 16'h1248 |=> wr_rejected == ($past(wdata) > 16'h0050))
    else $error("braking force range wrong");
  chk_enable_codes: assert property (wr && addr == 16'h1245 |=> wr_rejected == ($past(wdata) > 16'h0002))
    else $error("brake enable code range wrong");
  chk_m3_method: assert property (wr && addr == 16'h323e |=> wr_rejected == ($past(wdata) > 16'h0001))
    else $error("motor 3 method range wrong");
  chk_reserved_write: assert property (wr && (addr == 16'h1242 || addr == 16'h223f) |=> wr_rejected)
    else $error("reserved write accepted");
  chk_reserved_read: assert property (rd && addr == 16'h223f |=> rdata == 16'h0000)
    else $error("reserved read not zero");
  chk_mode_onehot: assert property ($onehot(control_mode_m1))
    else $error("method decode not one-hot");
  chk_force_idle: assert property (!dcb_active |-> dcb_force == 16'h0000)
    else $error("force shown while idle");
  chk_limit_commit: assert property ($changed(freq_upper_limit) |-> $past(wr && addr == 16'h1250))
    else $error("limit moved without low word write");
  chk_limit_range: assert property (freq_upper_limit == 32'h0 ||
    (freq_upper_limit >= 32'h32 && freq_upper_limit <= 32'h9c40))
    else $error("limit out of range");
endmodule : param_bank_chk

bind drive_boost_brake_param_bank param_bank_chk u_param_bank_chk (.core_clk, .rst, .addr,
  .wdata, .wr, .rd, .rdata, .wr_rejected, .dcb_active, .dcb_force, .control_mode_m1,
  .freq_upper_limit);

// [tb/drive_boost_brake_param_bank_bench.sv]
`timescale 1ns/10ps
module drive_boost_brake_param_bank_bench;
  import param_bank_pkg::*;
  localparam int STEP = 4;
  logic        core_clk, rst, wr, rd, wr_rejected, external_brake_input, large_model;
  logic        decelerating, start_request, dcb_active, start_brake_done, auto_boost_m1, rej;
  logic [15:0] addr, wdata, rdata, output_freq, dcb_force, dcb_carrier, d, a, lo, hi;
  logic [31:0] maximum_output_frequency, freq_upper_limit;
  logic [5:0]  control_mode_m1;
  int          failures, n_compared, n;
  // address, lowest, highest, reset value
  logic [63:0] tbl [22] = '{64'h123b_0000_0001_0000, 64'h323c_0000_00c8_0000,
    64'h123d_0000_01f4_0000, 64'h223d_0000_01f4_0000, 64'h323d_0000_01f4_0000,
    64'h123e_0000_0005_0000, 64'h223e_0000_0004_0000, 64'h323e_0000_0001_0000,
    64'h123f_0014_00c8_0064, 64'h1240_0000_00ff_0064, 64'h2240_0000_00ff_0064,
    64'h1241_0000_00ff_0064, 64'h2241_0000_00ff_0064, 64'h1245_0000_0002_0000,
    64'h1246_0000_9c40_0000, 64'h1247_0000_0032_0000, 64'h1248_0000_0050_0000,
    64'h1249_0000_0258_0000, 64'h124a_0000_0001_0000, 64'h124b_0000_0050_0000,
    64'h124c_0000_0258_0000, 64'h124d_0005_0096_0005};
  logic [15:0] rsv [4] = '{16'h1242, 16'h223f, 16'h124e, 16'h323f};

  drive_boost_brake_param_bank #(.STEP_CYCLES(STEP)) u_drive_boost_brake_param_bank (.core_clk,
    .rst, .addr, .wdata, .wr, .rd, .rdata, .wr_rejected, .external_brake_input, .large_model,
    .decelerating, .start_request, .output_freq, .maximum_output_frequency, .dcb_active,
    .dcb_force, .dcb_carrier, .start_brake_done, .control_mode_m1, .auto_boost_m1,
    .freq_upper_limit);
  net_master u_net_master (.core_clk, .rdata, .wr_rejected, .addr, .wdata, .wr, .rd);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic wr_ok(input logic [15:0] ad, input logic [15:0] dd);
    u_net_master.write(ad, dd, rej);
    check(rej, 0);
  endtask : wr_ok

  // bounded: a hang counts as a mismatch and ends the run
  task automatic wait_brake(input logic val, input int bound);
    n = 0;
    while (dcb_active !== val)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > bound)
      begin
        check(dcb_active, val);
        complete_run;
      end
    end
  endtask : wait_brake

  task automatic quiet(input int cycles);
    repeat (cycles)
    begin
      @(posedge core_clk);
      #1 check(dcb_active, 0);
    end
  endtask : quiet

  initial
  begin
    rst = 1'b1;
    failures = 0;
    n_compared = 0;
    {external_brake_input, large_model, decelerating, start_request} = 4'h0;
    output_freq = 16'h0000;
    maximum_output_frequency = 32'h0001_0000;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    foreach (tbl[i])
    begin
      u_net_master.read(tbl[i][63:48], d);
      check(d, tbl[i][15:0]);
    end
    foreach (tbl[i])
    begin
      {a, lo, hi} = tbl[i][63:16];
      wr_ok(a, hi);
      u_net_master.write(a, hi + 16'h0001, rej);
      check(rej, 1);
      u_net_master.read(a, d);
      check(d, hi);
      if (lo != 16'h0000)
      begin
        u_net_master.write(a, lo - 16'h0001, rej);
        check(rej, 1);
      end
      wr_ok(a, lo);
      u_net_master.read(a, d);
      check(d, lo);
    end
    for (int k = 0; k < 6; k++)
    begin
      wr_ok(16'h123e, 16'(k));
      @(posedge core_clk);
      #1 check(control_mode_m1, 6'h01 << k);
    end
    wr_ok(16'h123b, 16'h0001);
    @(posedge core_clk);
    #1 check(auto_boost_m1, 1);
    large_model <= 1'b1;
    repeat (4) @(posedge core_clk);
    u_net_master.write(16'h124d, 16'h0065, rej);
    check(rej, 1);
    wr_ok(16'h124d, 16'h0064);
    @(posedge core_clk);
    #1 check(dcb_carrier, 16'h0064);
    foreach (rsv[i])
    begin
      u_net_master.write(rsv[i], 16'h0001, rej);
      check(rej, 1);
      u_net_master.read(rsv[i], d);
      check(d, 0);
    end
    $display("test registers done");
    u_net_master.write_limit(16'h0000, 16'h9c40, rej);
    check(rej, 0);
    u_net_master.write_limit(16'h0000, 16'h0031, rej);
    check(rej, 1);
    u_net_master.write_limit(16'h0001, 16'h0000, rej);
    check(rej, 1);
    @(posedge core_clk);
    #1 check(freq_upper_limit, 32'h9c40);
    maximum_output_frequency <= 32'h0000_9c40;
    u_net_master.write_limit(16'h0000, 16'h9c40, rej);
    check(rej, 1);
    u_net_master.write_limit(16'h0000, 16'h0000, rej);
    check(rej, 0);
    u_net_master.write_limit(16'h0000, 16'h0032, rej);
    u_net_master.read(16'h1250, d);
    check(d, 16'h0032);
    check(freq_upper_limit, 32'h32);
    $display("test limit done");
    wr_ok(16'h1247, 16'h0000);
    wr_ok(16'h1248, 16'h001e);
    wr_ok(16'h1249, 16'h0001);
    wr_ok(16'h1246, 16'h00c8);
    wr_ok(16'h124b, 16'h0028);
    wr_ok(16'h124c, 16'h0002);
    wr_ok(16'h1245, 16'h0001);
    output_freq <= 16'h012c;
    decelerating <= 1'b1;
    quiet(12);
    output_freq <= 16'h0064;
    wait_brake(1, 10);
    check(dcb_force, 16'h001e);
    decelerating <= 1'b0;
    wait_brake(0, 20);
    wr_ok(16'h1247, 16'h0002);
    @(posedge core_clk);
    decelerating <= 1'b1;
    wait_brake(1, 40);
    check(n >= 2 * STEP, 1);
    decelerating <= 1'b0;
    wait_brake(0, 20);
    wr_ok(16'h1247, 16'h0000);
    @(posedge core_clk);
    start_request <= 1'b1;
    @(posedge core_clk);
    start_request <= 1'b0;
    wait_brake(1, 10);
    check(dcb_force, 16'h0028);
    wait_brake(0, 20);
    check(n >= 2 * STEP, 1);
    check(start_brake_done, 1);
    @(posedge core_clk);
    #1 check(start_brake_done, 0);
    $display("test braking done");
    wr_ok(16'h124a, 16'h0001);
    external_brake_input <= 1'b1;
    wait_brake(1, 10);
    repeat (3 * STEP) @(posedge core_clk);
    #1 check(dcb_active, 1);
    external_brake_input <= 1'b0;
    wait_brake(0, 10);
    wr_ok(16'h124a, 16'h0000);
    external_brake_input <= 1'b1;
    wait_brake(1, 10);
    wait_brake(0, 3 * STEP);
    external_brake_input <= 1'b0;
    wr_ok(16'h1245, 16'h0002);
    external_brake_input <= 1'b1;
    quiet(10);
    output_freq <= 16'h0064;
    decelerating <= 1'b1;
    wait_brake(1, 10);
    check(dcb_active, 1);
    decelerating <= 1'b0;
    wait_brake(0, 20);
    check(start_brake_done, 0);
    wr_ok(16'h1245, 16'h0000);
    decelerating <= 1'b1;
    quiet(10);
    $display("test inputs done");
    complete_run;
  end
endmodule : drive_boost_brake_param_bank_bench
